// *** aem_entry_matcher.sv ***
// Access control entry matcher for IP and ARP/RARP frame fields
//
// Chosen here: strobed register access and the address map.
`default_nettype none
`timescale 1ns/1ps

module aem_entry_matcher
    import aem_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              frm_valid,
    input  wire aem_frame_t        frm_in,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   match_valid,
    output logic                   match_hit
);

    // ************************************************************
    // Functions
    // ************************************************************

    // Three-way check: code 1 needs the test false, code 2 needs it true
    function automatic logic tri_ok(input logic [1:0] sel, input logic cond,
                                    input logic present);
        logic ok;
        ok = 1'b1;
        case (sel)
            AEM_TRI_ZERO: ok = present & ~cond;
            AEM_TRI_ONE:  ok = present & cond;
            default:      ok = 1'b1;
        endcase
        return ok;
    endfunction

    // Address registers sit at offsets one through eight
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return (a >= OFS_DST_IP) && (a <= OFS_TGT_MASK);
    endfunction

    function automatic logic [2:0] addr_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - OFS_DST_IP;
        return d[2:0];
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    logic [CTRL_USED_W-1:0] ctrl_reg;
    logic [31:0]            ip_regs [ADDR_REG_NUM];
    logic [DATA_W-1:0]      rdata_reg;
    logic                   match_valid_reg;
    logic                   match_hit_reg;
    logic                   seen_reg;
    logic [15:0]            hit_cnt_reg;
    logic [15:0]            frm_cnt_reg;

    wire logic [15:0] hit_cnt_next = hit_cnt_reg + 16'h0001;
    wire logic [15:0] frm_cnt_next = frm_cnt_reg + 16'h0001;

    // ************************************************************
    // Configuration decode
    // ************************************************************
    aem_cfg_t cfg;
    assign cfg.dip_mode = ctrl_reg[POS_DIP_MODE +: 2];
    assign cfg.sip_mode = ctrl_reg[POS_SIP_MODE +: 2];
    assign cfg.op_type  = ctrl_reg[POS_OP_TYPE  +: 2];
    assign cfg.req_rep  = ctrl_reg[POS_REQ_REP  +: 2];
    assign cfg.snd_mode = ctrl_reg[POS_SND_MODE +: 2];
    assign cfg.tgt_mode = ctrl_reg[POS_TGT_MODE +: 2];
    assign cfg.sha_chk  = ctrl_reg[POS_SHA_CHK  +: 2];
    assign cfg.tha_chk  = ctrl_reg[POS_THA_CHK  +: 2];
    assign cfg.len_chk  = ctrl_reg[POS_LEN_CHK  +: 2];
    assign cfg.hrd_chk  = ctrl_reg[POS_HRD_CHK  +: 2];
    assign cfg.pro_chk  = ctrl_reg[POS_PRO_CHK  +: 2];

    wire logic [31:0] dst_ip_cfg   = ip_regs[addr_idx(OFS_DST_IP)];
    wire logic [31:0] dst_mask_cfg = ip_regs[addr_idx(OFS_DST_MASK)];
    wire logic [31:0] src_ip_cfg   = ip_regs[addr_idx(OFS_SRC_IP)];
    wire logic [31:0] src_mask_cfg = ip_regs[addr_idx(OFS_SRC_MASK)];
    wire logic [31:0] snd_ip_cfg   = ip_regs[addr_idx(OFS_SND_IP)];
    wire logic [31:0] snd_mask_cfg = ip_regs[addr_idx(OFS_SND_MASK)];
    wire logic [31:0] tgt_ip_cfg   = ip_regs[addr_idx(OFS_TGT_IP)];
    wire logic [31:0] tgt_mask_cfg = ip_regs[addr_idx(OFS_TGT_MASK)];

    // ************************************************************
    // Frame classification
    // ************************************************************
    wire logic is_arp    = (frm_in.ethertype == ETYPE_ARP);
    wire logic is_rarp   = (frm_in.ethertype == ETYPE_RARP);
    wire logic arp_like  = is_arp | is_rarp;
    wire logic op_arp    = (frm_in.op == OP_ARP_REQ)  | (frm_in.op == OP_ARP_REP);
    wire logic op_rarp   = (frm_in.op == OP_RARP_REQ) | (frm_in.op == OP_RARP_REP);
    wire logic op_req    = (frm_in.op == OP_ARP_REQ)  | (frm_in.op == OP_RARP_REQ);
    wire logic op_rep    = (frm_in.op == OP_ARP_REP)  | (frm_in.op == OP_RARP_REP);
    wire logic len_std   = (frm_in.hln == HLN_ETH) & (frm_in.pln == PLN_IPV4);
    wire logic hrd_eth   = (frm_in.hrd == HRD_ETH);
    wire logic pro_ip    = (frm_in.pro == PRO_IP);
    wire logic sha_same  = (frm_in.sha == frm_in.src_mac);
    wire logic tha_same  = (frm_in.tha == frm_in.src_mac);

    // ************************************************************
    // Address comparisons
    // ************************************************************
    logic dst_ok;
    logic src_ok;
    logic snd_ok;
    logic tgt_ok;

    aem_ip_cmp u_dst_cmp (
        .mode     (cfg.dip_mode),
        .present  (frm_in.ipv4),
        .frame_ip (frm_in.dst_ip),
        .cfg_ip   (dst_ip_cfg),
        .cfg_mask (dst_mask_cfg),
        .hit      (dst_ok)
    );

    aem_ip_cmp u_src_cmp (
        .mode     (cfg.sip_mode),
        .present  (frm_in.ipv4),
        .frame_ip (frm_in.src_ip),
        .cfg_ip   (src_ip_cfg),
        .cfg_mask (src_mask_cfg),
        .hit      (src_ok)
    );

    aem_ip_cmp u_snd_cmp (
        .mode     (cfg.snd_mode),
        .present  (arp_like),
        .frame_ip (frm_in.spa),
        .cfg_ip   (snd_ip_cfg),
        .cfg_mask (snd_mask_cfg),
        .hit      (snd_ok)
    );

    aem_ip_cmp u_tgt_cmp (
        .mode     (cfg.tgt_mode),
        .present  (arp_like),
        .frame_ip (frm_in.tpa),
        .cfg_ip   (tgt_ip_cfg),
        .cfg_mask (tgt_mask_cfg),
        .hit      (tgt_ok)
    );

    // ************************************************************
    // Opcode conditions
    // ************************************************************
    // Unused code three of the request/reply field acts as don't-care
    wire logic op_ok =
        (cfg.op_type == AEM_OP_ARP)   ? (arp_like & op_arp) :
        (cfg.op_type == AEM_OP_RARP)  ? (arp_like & op_rarp) :
        (cfg.op_type == AEM_OP_OTHER) ? (arp_like & ~op_arp & ~op_rarp) :
        1'b1;
    wire logic rr_ok =
        (cfg.req_rep == AEM_RR_REQ) ? (arp_like & op_req) :
        (cfg.req_rep == AEM_RR_REP) ? (arp_like & op_rep) :
        1'b1;

    // ************************************************************
    // Header checks
    // ************************************************************
    // Hardware address checks only qualify their own frame kind
    wire logic sha_ok = tri_ok(cfg.sha_chk, sha_same, is_arp);
    wire logic tha_ok = tri_ok(cfg.tha_chk, tha_same, is_rarp);
    wire logic len_ok = tri_ok(cfg.len_chk, len_std, arp_like);
    wire logic hrd_ok = tri_ok(cfg.hrd_chk, hrd_eth, arp_like);
    wire logic pro_ok = tri_ok(cfg.pro_chk, pro_ip, arp_like);

    wire logic all_ok = dst_ok & src_ok & op_ok & rr_ok & snd_ok & tgt_ok
                      & sha_ok & tha_ok & len_ok & hrd_ok & pro_ok;

    // ************************************************************
    // Register port decode
    // ************************************************************
    wire logic wr_ctrl  = reg_wr && (reg_addr == OFS_CTRL);
    wire logic wr_addr  = reg_wr && addr_hit(reg_addr);
    wire logic [2:0] wr_idx = addr_idx(reg_addr);

    wire logic [DATA_W-1:0] rd_mux =
        (reg_addr == OFS_CTRL)   ? {{(DATA_W-CTRL_USED_W){1'b0}}, ctrl_reg} :
        addr_hit(reg_addr)       ? ip_regs[addr_idx(reg_addr)] :
        (reg_addr == OFS_STATUS) ? {30'h0, seen_reg, match_hit_reg} :
        (reg_addr == OFS_COUNT)  ? {frm_cnt_reg, hit_cnt_reg} :
        32'h0000_0000;

    // ************************************************************
    // Sequential logic
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_reg <= RST_CTRL[CTRL_USED_W-1:0];
        end else if (wr_ctrl) begin
            ctrl_reg <= reg_wdata[CTRL_USED_W-1:0];
        end
    end

    // Masks reset to all ones so a stray Network mode acts as Host
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < ADDR_REG_NUM; i++) begin
                ip_regs[i] <= i[0] ? RST_MASK : RST_ADDR;
            end
        end else if (wr_addr) begin
            ip_regs[wr_idx] <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // Result lands one clock after the frame fields
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            match_valid_reg <= 1'b0;
            match_hit_reg   <= 1'b0;
        end else begin
            match_valid_reg <= frm_valid;
            match_hit_reg   <= frm_valid & all_ok;
        end
    end

    // Counters wrap; software samples them as a pair in one read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seen_reg    <= 1'b0;
            hit_cnt_reg <= RST_COUNT;
            frm_cnt_reg <= RST_COUNT;
        end else if (frm_valid) begin
            seen_reg    <= 1'b1;
            frm_cnt_reg <= frm_cnt_next;
            hit_cnt_reg <= all_ok ? hit_cnt_next : hit_cnt_reg;
        end
    end

    assign reg_rdata   = rdata_reg;
    assign match_valid = match_valid_reg;
    assign match_hit   = match_hit_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    result_timing_a: assert property (
        frm_valid |=> match_valid ##1 (match_valid == $past(frm_valid)))
        else $error("match result not one clock after frame");

    hit_needs_valid_a: assert property (
        !frm_valid |=> !match_hit)
        else $error("match without a frame");

    all_any_a: assert property (
        (frm_valid && ctrl_reg == RST_CTRL[CTRL_USED_W-1:0]) |=> match_hit)
        else $error("all don't-care entry did not match");

    dst_host_a: assert property (
        (frm_valid && cfg.dip_mode == AEM_IP_HOST && frm_in.dst_ip != dst_ip_cfg)
        |=> !match_hit)
        else $error("host destination mismatch still matched");

    dst_net_a: assert property (
        (frm_valid && cfg.dip_mode == AEM_IP_NET
         && ((frm_in.dst_ip ^ dst_ip_cfg) & dst_mask_cfg) != 32'h0000_0000)
        |=> !match_hit)
        else $error("network destination mismatch still matched");

    src_net_a: assert property (
        (frm_valid && cfg.sip_mode == AEM_IP_NET
         && ((frm_in.src_ip ^ src_ip_cfg) & src_mask_cfg) != 32'h0000_0000)
        |=> !match_hit)
        else $error("network source mismatch still matched");

    non_arp_a: assert property (
        (frm_valid && !arp_like && cfg.op_type != AEM_OP_ANY) |=> !match_hit)
        else $error("opcode condition matched a non-ARP frame");

    reply_op_a: assert property (
        (frm_valid && cfg.req_rep == AEM_RR_REP && !op_rep) |=> !match_hit)
        else $error("reply condition matched a non-reply opcode");

    sha_check_a: assert property (
        (frm_valid && cfg.sha_chk == AEM_TRI_ONE && frm_in.sha != frm_in.src_mac)
        |=> !match_hit)
        else $error("sender hardware address check passed wrongly");

    len_check_a: assert property (
        (frm_valid && cfg.len_chk == AEM_TRI_ZERO && len_std) |=> !match_hit)
        else $error("length check passed on standard lengths");

    pro_check_a: assert property (
        (frm_valid && cfg.pro_chk == AEM_TRI_ONE && !pro_ip) |=> !match_hit)
        else $error("protocol space check passed wrongly");

    read_data_a: assert property (
        (reg_rd && reg_addr == OFS_CTRL) |=> (reg_rdata[CTRL_USED_W-1:0] == $past(ctrl_reg)))
        else $error("control readback wrong");

endmodule // aem_entry_matcher

`default_nettype wire

// *** aem_ip_cmp.sv ***
// Shared constants and types, plus the masked IPv4 address comparator
`timescale 1ns/1ps
`default_nettype none

package aem_pkg;

    // ************************************************************
    // Register port
    // ************************************************************
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 32;
    localparam logic [3:0]  OFS_CTRL        = 4'h0;
    localparam logic [3:0]  OFS_DST_IP      = 4'h1;
    localparam logic [3:0]  OFS_DST_MASK    = 4'h2;
    localparam logic [3:0]  OFS_SRC_IP      = 4'h3;
    localparam logic [3:0]  OFS_SRC_MASK    = 4'h4;
    localparam logic [3:0]  OFS_SND_IP      = 4'h5;
    localparam logic [3:0]  OFS_SND_MASK    = 4'h6;
    localparam logic [3:0]  OFS_TGT_IP      = 4'h7;
    localparam logic [3:0]  OFS_TGT_MASK    = 4'h8;
    localparam logic [3:0]  OFS_STATUS      = 4'h9;
    localparam logic [3:0]  OFS_COUNT       = 4'hA;
    localparam int          ADDR_REG_NUM    = 8;

    // ************************************************************
    // Control field positions, each field two bits wide
    // ************************************************************
    localparam int          POS_DIP_MODE    = 0;
    localparam int          POS_SIP_MODE    = 2;
    localparam int          POS_OP_TYPE     = 4;
    localparam int          POS_REQ_REP     = 6;
    localparam int          POS_SND_MODE    = 8;
    localparam int          POS_TGT_MODE    = 10;
    localparam int          POS_SHA_CHK     = 12;
    localparam int          POS_THA_CHK     = 14;
    localparam int          POS_LEN_CHK     = 16;
    localparam int          POS_HRD_CHK     = 18;
    localparam int          POS_PRO_CHK     = 20;
    localparam int          CTRL_USED_W     = 22;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [31:0] RST_CTRL        = 32'h0000_0000;
    localparam logic [31:0] RST_ADDR        = 32'h0000_0000;
    localparam logic [31:0] RST_MASK        = 32'hFFFF_FFFF;
    localparam logic [15:0] RST_COUNT       = 16'h0000;

    // ************************************************************
    // Protocol constants
    // ************************************************************
    localparam logic [15:0] ETYPE_ARP       = 16'h0806;
    localparam logic [15:0] ETYPE_RARP      = 16'h8035;
    localparam logic [15:0] OP_ARP_REQ      = 16'h0001;
    localparam logic [15:0] OP_ARP_REP      = 16'h0002;
    localparam logic [15:0] OP_RARP_REQ     = 16'h0003;
    localparam logic [15:0] OP_RARP_REP     = 16'h0004;
    localparam logic [7:0]  HLN_ETH         = 8'h06;
    localparam logic [7:0]  PLN_IPV4        = 8'h04;
    localparam logic [15:0] HRD_ETH         = 16'h0001;
    localparam logic [15:0] PRO_IP          = 16'h0800;
    localparam logic [31:0] MASK_HOST       = 32'hFFFF_FFFF;

    // ************************************************************
    // Modes and carriers
    // ************************************************************
    typedef enum logic [1:0] {AEM_IP_ANY, AEM_IP_HOST, AEM_IP_NET}           aem_ip_mode_t;
    typedef enum logic [1:0] {AEM_OP_ANY, AEM_OP_ARP, AEM_OP_RARP, AEM_OP_OTHER} aem_op_t;
    typedef enum logic [1:0] {AEM_RR_ANY, AEM_RR_REQ, AEM_RR_REP}            aem_rr_t;
    typedef enum logic [1:0] {AEM_TRI_ANY, AEM_TRI_ZERO, AEM_TRI_ONE}        aem_tri_t;

    typedef struct packed {
        logic [15:0] ethertype;
        logic [47:0] src_mac;
        logic        ipv4;
        logic [31:0] src_ip;
        logic [31:0] dst_ip;
        logic [15:0] hrd;
        logic [15:0] pro;
        logic [7:0]  hln;
        logic [7:0]  pln;
        logic [15:0] op;
        logic [47:0] sha;
        logic [31:0] spa;
        logic [47:0] tha;
        logic [31:0] tpa;
    } aem_frame_t;

    typedef struct packed {
        logic [1:0] dip_mode;
        logic [1:0] sip_mode;
        logic [1:0] op_type;
        logic [1:0] req_rep;
        logic [1:0] snd_mode;
        logic [1:0] tgt_mode;
        logic [1:0] sha_chk;
        logic [1:0] tha_chk;
        logic [1:0] len_chk;
        logic [1:0] hrd_chk;
        logic [1:0] pro_chk;
    } aem_cfg_t;

endpackage

module aem_ip_cmp
    import aem_pkg::*;
(
    input  wire logic [1:0]  mode,
    input  wire logic        present,
    input  wire logic [31:0] frame_ip,
    input  wire logic [31:0] cfg_ip,
    input  wire logic [31:0] cfg_mask,
    output logic             hit
);
    // Host mode behaves as an all-ones mask; the mask setting is ignored there
    wire logic [31:0] eff_mask = (mode == AEM_IP_NET) ? cfg_mask : MASK_HOST;
    wire logic        same     = ((frame_ip & eff_mask) == (cfg_ip & eff_mask));

    // Codes outside the defined set fall back to don't-care
    assign hit = (mode == AEM_IP_HOST || mode == AEM_IP_NET) ? (present & same) : 1'b1;
endmodule // aem_ip_cmp

`default_nettype wire

// *** aem_frame_src.sv ***
// Frame source model standing in for the switch parsing pipeline
`timescale 1ns/1ps
`default_nettype none

module aem_frame_src
    import aem_pkg::*;
(
    input  wire logic  sys_clk,
    output var logic   frm_valid,
    output aem_frame_t frm_in
);
    initial begin
        frm_valid = 1'b0;
        frm_in    = '0;
    end

    // Fields go to the inverse after the pulse so a late sample cannot pass
    task automatic send(input aem_frame_t f);
        @(posedge sys_clk);
        frm_valid <= 1'b1;
        frm_in    <= f;
        @(posedge sys_clk);
        frm_valid <= 1'b0;
        frm_in    <= ~f;
    endtask
endmodule // aem_frame_src

`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the access control entry matcher
`timescale 1ns/1ps
`default_nettype none

module tb
    import aem_pkg::*;
;
    localparam logic [15:0] ET_IPV4 = 16'h0800;
    logic              sys_clk;
    logic              rst;
    logic              frm_valid;
    aem_frame_t        frm_in;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              match_valid;
    logic              match_hit;
    int                miscompares;
    int                tests_run;

    aem_frame_src src_u (.sys_clk(sys_clk), .frm_valid(frm_valid), .frm_in(frm_in));

    aem_entry_matcher dut_u (
        .sys_clk(sys_clk), .rst(rst), .frm_valid(frm_valid), .frm_in(frm_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .match_valid(match_valid), .match_hit(match_hit)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        cmp_reg("reg_rdata", e, reg_rdata);
    endtask

    // Answer is fixed one cycle after the pulse, so it is judged right there
    task automatic try(input aem_frame_t f, input logic e);
        src_u.send(f);
        #1;
        cmp_bit("match_valid", 1'b1, match_valid);
        cmp_bit("match_hit", e, match_hit);
    endtask

    function automatic logic [31:0] fld(input int pos, input int v);
        return 32'(v[1:0]) << pos;
    endfunction

    function automatic aem_frame_t mk(input logic [15:0] et, input logic [15:0] op);
        aem_frame_t f;
        f = '{ethertype: et, src_mac: 48'h0A0B_0C0D_0E0F, ipv4: (et == ET_IPV4),
              src_ip: 32'h0A00_0001, dst_ip: 32'h0A00_0102, hrd: HRD_ETH, pro: PRO_IP,
              hln: HLN_ETH, pln: PLN_IPV4, op: op, sha: 48'h0A0B_0C0D_0E0F,
              spa: 32'hC0A8_0101, tha: 48'h0A0B_0C0D_0E0F, tpa: 32'hC0A8_01FE};
        return f;
    endfunction

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        rd(OFS_CTRL, RST_CTRL);
        rd(OFS_SND_IP, RST_ADDR);
        wr(4'hB, 32'hFFFF_FFFF);
        rd(4'hB, 32'h0000_0000);
        rd(OFS_DST_MASK, RST_MASK);
        @(posedge sys_clk);
        #1;
        cmp_reg("reg_rdata idle", 32'h0000_0000, reg_rdata);
        try(mk(ETYPE_ARP, OP_ARP_REQ), 1'b1);
        @(posedge sys_clk);
        #1;
        cmp_bit("match_valid idle", 1'b0, match_valid);
        rd(OFS_STATUS, 32'h0000_0002);
        rd(OFS_COUNT, 32'h0001_0001);
    endtask

    task automatic t_dst_src;
        aem_frame_t f;
        f = mk(ET_IPV4, 16'h0000);
        wr(OFS_DST_IP, f.dst_ip ^ 32'h0000_0001);
        try(f, 1'b1);
        wr(OFS_CTRL, fld(POS_DIP_MODE, 1));
        try(f, 1'b0);
        wr(OFS_DST_IP, f.dst_ip);
        try(f, 1'b1);
        wr(OFS_DST_IP, f.dst_ip ^ 32'h0000_00FF);
        wr(OFS_DST_MASK, 32'hFFFF_FF00);
        wr(OFS_CTRL, fld(POS_DIP_MODE, 2));
        try(f, 1'b1);
        wr(OFS_DST_MASK, 32'hFFFF_FF80);
        try(f, 1'b0);
        wr(OFS_SRC_IP, f.src_ip ^ 32'h1000_0000);
        wr(OFS_SRC_MASK, 32'h0000_0000);
        wr(OFS_CTRL, fld(POS_SIP_MODE, 1));
        try(f, 1'b0);
        wr(OFS_CTRL, fld(POS_SIP_MODE, 2));
        try(f, 1'b1);
    endtask

    task automatic t_opcode;
        logic e;
        for (int op = 1; op <= 5; op++) begin
            for (int t = 0; t < 4; t++) begin
                e = (t == 0) || (t == 1 && op <= 2) || (t == 2 && (op == 3 || op == 4))
                    || (t == 3 && op == 5);
                wr(OFS_CTRL, fld(POS_OP_TYPE, t));
                try(mk(op > 2 ? ETYPE_RARP : ETYPE_ARP, 16'(op)), e);
            end
            for (int r = 0; r < 3; r++) begin
                e = (r == 0) || (op < 5 && (r == 1) == (op % 2 == 1));
                wr(OFS_CTRL, fld(POS_REQ_REP, r));
                try(mk(op > 2 ? ETYPE_RARP : ETYPE_ARP, 16'(op)), e);
            end
        end
    endtask

    task automatic t_arp_ip;
        aem_frame_t f;
        f = mk(ETYPE_ARP, OP_ARP_REP);
        wr(OFS_SND_IP, 32'hC0A8_0100);
        wr(OFS_SND_MASK, 32'hFFFF_FF00);
        wr(OFS_TGT_IP, f.spa);
        wr(OFS_CTRL, fld(POS_SND_MODE, 2));
        try(f, 1'b1);
        wr(OFS_CTRL, fld(POS_SND_MODE, 1));
        try(f, 1'b0);
        wr(OFS_CTRL, fld(POS_SND_MODE, 2) | fld(POS_TGT_MODE, 1));
        try(f, 1'b0);
        wr(OFS_TGT_IP, f.tpa);
        try(f, 1'b1);
    endtask

    // Code 1 wants the test false, code 2 wants it true, 0 and 3 ignore it
    task automatic t_checks;
        int pos [5] = '{POS_SHA_CHK, POS_THA_CHK, POS_LEN_CHK, POS_HRD_CHK, POS_PRO_CHK};
        aem_frame_t f;
        for (int k = 0; k < 5; k++) begin
            for (int b = 0; b < 2; b++) begin
                f = (k == 1) ? mk(ETYPE_RARP, OP_RARP_REQ) : mk(ETYPE_ARP, OP_ARP_REQ);
                if (b == 1) begin
                    case (k)
                        0: f.sha[0] = ~f.sha[0];
                        1: f.tha[0] = ~f.tha[0];
                        2: f.hln = 8'h08;
                        3: f.hrd = 16'h0006;
                        default: f.pro = 16'h86DD;
                    endcase
                end
                for (int v = 0; v < 4; v++) begin
                    wr(OFS_CTRL, fld(pos[k], v));
                    try(f, (b == 1) ? (v != 2) : (v != 1));
                end
            end
        end
    endtask

    task automatic t_non_arp;
        wr(OFS_CTRL, fld(POS_OP_TYPE, 1));
        try(mk(ET_IPV4, OP_ARP_REQ), 1'b0);
        wr(OFS_CTRL, fld(POS_SHA_CHK, 2));
        try(mk(ET_IPV4, OP_ARP_REQ), 1'b0);
        wr(OFS_CTRL, 32'h0000_0000);
        try(mk(ET_IPV4, OP_ARP_REQ), 1'b1);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        rst         = 1'b1;
        reg_addr    = '0;
        reg_wdata   = '0;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        miscompares = 0;
        tests_run   = 0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset;
        t_dst_src;
        t_opcode;
        t_arp_ip;
        t_checks;
        t_non_arp;
        conclude;
    end

    // Roughly 190 frames and writes of a few cycles each fit well inside this
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        conclude;
    end
endmodule // tb

`default_nettype wire
